// File: dwc_pkg.sv
// Constants and types shared by the display command host and device ends
package dwc_pkg;

	// Command codes
	localparam logic [7:0] DWC_CMD_SOFT_RESET = 8'h01;
	localparam logic [7:0] DWC_CMD_DISPLAY_ENABLE = 8'h29;
	localparam logic [7:0] DWC_CMD_COLUMN_WINDOW = 8'h2a;
	localparam logic [7:0] DWC_CMD_ROW_WINDOW = 8'h2b;
	localparam logic [7:0] DWC_CMD_MEMORY_WRITE = 8'h2c;

	// Window parameter sequence
	localparam logic [1:0] DWC_PARAM_FIRST = 2'h0;
	localparam logic [1:0] DWC_PARAM_START_LO = 2'h1;
	localparam logic [1:0] DWC_PARAM_END_HI = 2'h2;
	localparam logic [1:0] DWC_PARAM_LAST = 2'h3;

	// Gate line modes and address limits
	localparam logic [1:0] DWC_GM_208 = 2'h0;
	localparam logic [1:0] DWC_GM_220 = 2'h1;
	localparam logic [15:0] DWC_MAX_176 = 16'h00af;
	localparam logic [15:0] DWC_MAX_208 = 16'h00cf;
	localparam logic [15:0] DWC_MAX_220 = 16'h00db;
	localparam logic [15:0] DWC_MAX_240 = 16'h00ef;
	localparam logic [15:0] DWC_START_DEFAULT = 16'h0000;

	// Cycles after reset before the strap-dependent defaults load
	localparam logic [1:0] DWC_INIT_CYC = 2'h3;

	// Write strobe timing
	localparam int DWC_CLK_NS = 10;
	localparam int DWC_WR_LOW_NS = 40;
	localparam int DWC_WR_HIGH_NS = 40;
	localparam logic [7:0] DWC_WR_LOW_CYC = 8'((DWC_WR_LOW_NS + DWC_CLK_NS - 1) / DWC_CLK_NS);
	localparam logic [7:0] DWC_WR_HIGH_CYC = 8'((DWC_WR_HIGH_NS + DWC_CLK_NS - 1) / DWC_CLK_NS);

	// Host register map
	localparam logic [7:0] DWC_SEND_OFF = 8'h00;
	localparam logic [7:0] DWC_STATUS_OFF = 8'h04;
	localparam int DWC_SEND_DCS_BIT = 8;
	localparam int DWC_ST_BUSY_BIT = 0;
	localparam int DWC_ST_ORDER_ERR_BIT = 1;
	localparam logic [31:0] DWC_ZERO_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {DS_IDLE, DS_COL, DS_ROW, DS_MEM} dwc_dev_st_t;
	typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH} dwc_host_st_t;

endpackage : dwc_pkg

// File: dwc_link_if.sv
// Host to display command link: select, write strobe and byte
`timescale 1ns/10ps
interface dwc_link_if;
	logic       data_command_select;
	logic       wr_n;
	logic [7:0] data;

	modport host (output data_command_select, output wr_n, output data);
	modport device (input data_command_select, input wr_n, input data);
endinterface : dwc_link_if

// File: dwc_device.sv
// Display enable and column/row window command decoder, device end
// Summary of operation
// - Display enable is one command byte, leaves off
// - Enabled display shows frame memory, not blank
// - Display enable touches no other state
// - Display enable when already on does nothing
// - Column window: four bytes, used at memory write
// - Host keeps column start not above end; dwc_host still sends start above end and only sets the order error bit
// - Columns beyond maximum column address are ignored
// - Row window: four bytes, used at memory write
// - Host keeps row start not above end; dwc_host still sends start above end and only sets the order error bit
// - Rows beyond maximum row address are ignored
// - Window load changes only the window bounds
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module dwc_device (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rstn_i,
	// Link from host
	dwc_link_if.device          link,
	// Straps
	input  wire logic [1:0]     gate_line_mode_i,
	input  wire logic           row_column_swap_i,
	// Display state
	output logic                display_enable_o,
	output logic                frame_to_panel_o,
	// Stored window
	output logic [15:0]         column_start_o,
	output logic [15:0]         column_end_o,
	output logic [15:0]         row_start_o,
	output logic [15:0]         row_end_o,
	// Limits in force
	output logic [15:0]         column_max_o,
	output logic [15:0]         row_max_o,
	// Memory write window, clipped to the limits
	output logic                memory_write_start_o,
	output logic [15:0]         act_column_start_o,
	output logic [15:0]         act_column_end_o,
	output logic [15:0]         act_row_start_o,
	output logic [15:0]         act_row_end_o,
	output logic                act_window_ok_o,
	// Pixel bytes of a memory write
	output logic [7:0]          pixel_data_o,
	output logic                pixel_valid_o
);
	import dwc_pkg::*;

	typedef struct packed {
		logic        dcs_s1;
		logic        dcs_s2;
		logic        wr_s1;
		logic        wr_s2;
		logic        wr_d;
		logic [7:0]  dat_s1;
		logic [7:0]  dat_s2;
		logic [1:0]  gm_s1;
		logic [1:0]  gm_s2;
		logic        swap_s1;
		logic        swap_s2;
		logic [1:0]  init_cnt;
		logic        disp_on;
		dwc_dev_st_t st;
		logic [1:0]  pidx;
		logic [15:0] col_start;
		logic [15:0] col_end;
		logic [15:0] row_start;
		logic [15:0] row_end;
		logic [15:0] col_max;
		logic [15:0] row_max;
		logic        mw_start;
		logic [15:0] act_cs;
		logic [15:0] act_ce;
		logic [15:0] act_rs;
		logic [15:0] act_re;
		logic        act_ok;
		logic [7:0]  px_data;
		logic        px_valid;
	} dwc_dev_state_t;

	dwc_dev_state_t s_r;
	dwc_dev_state_t s_nxt;

	// Longest line count for the gate line mode; undefined code takes 240
	function automatic logic [15:0] dwc_gm_max(input logic [1:0] gm);
		logic [15:0] m;
		m = DWC_MAX_240;
		if (gm == DWC_GM_208)
			m = DWC_MAX_208;
		else if (gm == DWC_GM_220)
			m = DWC_MAX_220;
		return m;
	endfunction : dwc_gm_max

	function automatic logic [15:0] dwc_clip(input logic [15:0] v, input logic [15:0] lim);
		return (v > lim) ? lim : v;
	endfunction : dwc_clip

	logic strobe_rise;
	logic [15:0] cmax;
	logic [15:0] rmax;

	always_comb
	begin
		s_nxt = s_r;
		// Two-stage synchronisers on every link and strap input
		s_nxt.dcs_s1 = link.data_command_select;
		s_nxt.dcs_s2 = s_r.dcs_s1;
		s_nxt.wr_s1 = link.wr_n;
		s_nxt.wr_s2 = s_r.wr_s1;
		s_nxt.wr_d = s_r.wr_s2;
		s_nxt.dat_s1 = link.data;
		s_nxt.dat_s2 = s_r.dat_s1;
		s_nxt.gm_s1 = gate_line_mode_i;
		s_nxt.gm_s2 = s_r.gm_s1;
		s_nxt.swap_s1 = row_column_swap_i;
		s_nxt.swap_s2 = s_r.swap_s1;
		s_nxt.mw_start = 1'b0;
		s_nxt.px_valid = 1'b0;

		// Limits follow the swap and gate line mode
		cmax = s_r.swap_s2 ? dwc_gm_max(s_r.gm_s2) : DWC_MAX_176;
		rmax = s_r.swap_s2 ? DWC_MAX_176 : dwc_gm_max(s_r.gm_s2);
		s_nxt.col_max = cmax;
		s_nxt.row_max = rmax;

		// Byte taken on rising edge of the synchronised strobe
		strobe_rise = s_r.wr_s2 & ~s_r.wr_d;

		// Defaults load once the straps have passed the synchronisers
		if (s_r.init_cnt != 2'h0)
		begin
			s_nxt.init_cnt = s_r.init_cnt - 2'h1;
			if (s_r.init_cnt == 2'h1)
			begin
				s_nxt.col_start = DWC_START_DEFAULT;
				s_nxt.col_end = DWC_MAX_176;
				s_nxt.row_start = DWC_START_DEFAULT;
				s_nxt.row_end = dwc_gm_max(s_r.gm_s2);
			end
		end

		if (strobe_rise && !s_r.dcs_s2)
		begin
			// Command byte: select low
			s_nxt.st = DS_IDLE;
			s_nxt.pidx = DWC_PARAM_FIRST;
			if (s_r.dat_s2 == DWC_CMD_DISPLAY_ENABLE)
			begin
				// Sets the flag only; nothing else moves, repeat is harmless
				s_nxt.disp_on = 1'b1;
			end
			else if (s_r.dat_s2 == DWC_CMD_COLUMN_WINDOW)
			begin
				s_nxt.st = DS_COL;
			end
			else if (s_r.dat_s2 == DWC_CMD_ROW_WINDOW)
			begin
				s_nxt.st = DS_ROW;
			end
			else if (s_r.dat_s2 == DWC_CMD_MEMORY_WRITE)
			begin
				// Stored bounds take effect here, clipped to the limits
				s_nxt.st = DS_MEM;
				s_nxt.mw_start = 1'b1;
				s_nxt.act_cs = dwc_clip(s_r.col_start, cmax);
				s_nxt.act_ce = dwc_clip(s_r.col_end, cmax);
				s_nxt.act_rs = dwc_clip(s_r.row_start, rmax);
				s_nxt.act_re = dwc_clip(s_r.row_end, rmax);
				s_nxt.act_ok = (s_r.col_start <= cmax) && (s_r.row_start <= rmax);
			end
			else if (s_r.dat_s2 == DWC_CMD_SOFT_RESET)
			begin
				s_nxt.disp_on = 1'b0;
				s_nxt.init_cnt = DWC_INIT_CYC;
			end
		end
		else if (strobe_rise)
		begin
			// Parameter byte: select high
			case (s_r.st)
				DS_COL:
				begin
					// Only the column bounds change
					if (s_r.pidx == DWC_PARAM_FIRST)
						s_nxt.col_start[15:8] = s_r.dat_s2;
					else if (s_r.pidx == DWC_PARAM_START_LO)
						s_nxt.col_start[7:0] = s_r.dat_s2;
					else if (s_r.pidx == DWC_PARAM_END_HI)
						s_nxt.col_end[15:8] = s_r.dat_s2;
					else
						s_nxt.col_end[7:0] = s_r.dat_s2;
				end
				DS_ROW:
				begin
					if (s_r.pidx == DWC_PARAM_FIRST)
						s_nxt.row_start[15:8] = s_r.dat_s2;
					else if (s_r.pidx == DWC_PARAM_START_LO)
						s_nxt.row_start[7:0] = s_r.dat_s2;
					else if (s_r.pidx == DWC_PARAM_END_HI)
						s_nxt.row_end[15:8] = s_r.dat_s2;
					else
						s_nxt.row_end[7:0] = s_r.dat_s2;
				end
				DS_MEM:
				begin
					// Whole window out of range: bytes are dropped
					s_nxt.px_data = s_r.dat_s2;
					s_nxt.px_valid = s_r.act_ok;
				end
				default:
				begin
					s_nxt.st = DS_IDLE;
				end
			endcase
			if (s_r.st == DS_COL || s_r.st == DS_ROW)
			begin
				s_nxt.pidx = s_r.pidx + 2'h1;
				if (s_r.pidx == DWC_PARAM_LAST)
					s_nxt.st = DS_IDLE;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s_r <= '0;
			s_r.wr_s1 <= 1'b1;
			s_r.wr_s2 <= 1'b1;
			s_r.wr_d <= 1'b1;
			s_r.init_cnt <= DWC_INIT_CYC;
			s_r.st <= DS_IDLE;
			s_r.col_end <= DWC_MAX_176;
			s_r.row_end <= DWC_MAX_208;
			s_r.col_max <= DWC_MAX_176;
			s_r.row_max <= DWC_MAX_208;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign display_enable_o = s_r.disp_on;
	assign frame_to_panel_o = s_r.disp_on;
	assign column_start_o = s_r.col_start;
	assign column_end_o = s_r.col_end;
	assign row_start_o = s_r.row_start;
	assign row_end_o = s_r.row_end;
	assign column_max_o = s_r.col_max;
	assign row_max_o = s_r.row_max;
	assign memory_write_start_o = s_r.mw_start;
	assign act_column_start_o = s_r.act_cs;
	assign act_column_end_o = s_r.act_ce;
	assign act_row_start_o = s_r.act_rs;
	assign act_row_end_o = s_r.act_re;
	assign act_window_ok_o = s_r.act_ok;
	assign pixel_data_o = s_r.px_data;
	assign pixel_valid_o = s_r.px_valid;

endmodule : dwc_device

// File: dwc_host.sv
// Host end: AHB-Lite registers that send command and parameter bytes
`timescale 1ns/10ps
module dwc_host (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rstn_i,
	// AHB-Lite slave
	input  wire logic           hsel_i,
	input  wire logic [31:0]    haddr_i,
	input  wire logic [1:0]     htrans_i,
	input  wire logic           hwrite_i,
	input  wire logic [2:0]     hsize_i,
	input  wire logic [31:0]    hwdata_i,
	input  wire logic           hready_i,
	output logic                hreadyout_o,
	output logic                hresp_o,
	output logic [31:0]         hrdata_o,
	// Link to device
	dwc_link_if.host            link
);
	import dwc_pkg::*;

	typedef struct packed {
		logic         ph_wr;
		logic         ph_send;
		logic         ph_stat;
		logic [31:0]  rdata;
		dwc_host_st_t st;
		logic [7:0]   cnt;
		logic         dcs;
		logic         wr_n;
		logic [7:0]   dat;
		logic [7:0]   sent;
		logic         in_win;
		logic [1:0]   pidx;
		logic [15:0]  start;
		logic         order_err;
	} dwc_host_state_t;

	dwc_host_state_t s_r;
	dwc_host_state_t s_nxt;

	logic busy;
	logic stall;
	logic send_now;
	logic [7:0] b;
	logic is_param;

	assign busy = (s_r.st != HS_IDLE);
	assign stall = s_r.ph_wr && s_r.ph_send && busy;
	assign hreadyout_o = ~stall;
	assign hresp_o = 1'b0;
	assign hrdata_o = s_r.rdata;

	always_comb
	begin
		s_nxt = s_r;
		send_now = s_r.ph_wr && s_r.ph_send && !busy;
		b = hwdata_i[7:0];
		is_param = hwdata_i[DWC_SEND_DCS_BIT];

		// Address phase
		if (hready_i)
		begin
			s_nxt.ph_wr = 1'b0;
			s_nxt.ph_send = 1'b0;
			s_nxt.ph_stat = 1'b0;
			if (hsel_i && htrans_i[1])
			begin
				s_nxt.ph_wr = hwrite_i;
				s_nxt.ph_send = (haddr_i[7:0] == DWC_SEND_OFF);
				s_nxt.ph_stat = (haddr_i[7:0] == DWC_STATUS_OFF);
				s_nxt.rdata = DWC_ZERO_WORD;
				if (!hwrite_i && haddr_i[7:0] == DWC_STATUS_OFF)
				begin
					s_nxt.rdata[DWC_ST_BUSY_BIT] = busy;
					s_nxt.rdata[DWC_ST_ORDER_ERR_BIT] = s_r.order_err;
					s_nxt.rdata[15:8] = s_r.sent;
				end
			end
		end

		// Strobe sequencer: low phase, then rising edge and high phase
		case (s_r.st)
			HS_LOW:
			begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01)
				begin
					s_nxt.wr_n = 1'b1;
					s_nxt.cnt = DWC_WR_HIGH_CYC;
					s_nxt.st = HS_HIGH;
				end
			end
			HS_HIGH:
			begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01)
				begin
					s_nxt.st = HS_IDLE;
					s_nxt.sent = s_r.sent + 8'h01;
				end
			end
			default:
			begin
				s_nxt.st = HS_IDLE;
			end
		endcase

		// Clear by writing a one to the error bit; a new error wins
		if (s_r.ph_wr && s_r.ph_stat && hwdata_i[DWC_ST_ORDER_ERR_BIT])
			s_nxt.order_err = 1'b0;

		if (send_now)
		begin
			s_nxt.dcs = is_param;
			s_nxt.dat = b;
			s_nxt.wr_n = 1'b0;
			s_nxt.cnt = DWC_WR_LOW_CYC;
			s_nxt.st = HS_LOW;
			// Watch window parameters for start above end
			if (!is_param)
			begin
				s_nxt.in_win = (b == DWC_CMD_COLUMN_WINDOW) || (b == DWC_CMD_ROW_WINDOW);
				s_nxt.pidx = DWC_PARAM_FIRST;
			end
			else if (s_r.in_win)
			begin
				s_nxt.pidx = s_r.pidx + 2'h1;
				if (s_r.pidx == DWC_PARAM_FIRST)
					s_nxt.start[15:8] = b;
				else if (s_r.pidx == DWC_PARAM_START_LO)
					s_nxt.start[7:0] = b;
				else if (s_r.pidx == DWC_PARAM_END_HI)
					s_nxt.start = s_r.start;
				else
				begin
					s_nxt.in_win = 1'b0;
					if (s_r.start > {s_r.dat, b})
						s_nxt.order_err = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s_r <= '0;
			s_r.st <= HS_IDLE;
			s_r.wr_n <= 1'b1;
			s_r.dcs <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign link.data_command_select = s_r.dcs;
	assign link.wr_n = s_r.wr_n;
	assign link.data = s_r.dat;

endmodule : dwc_host

// File: dwc_chk.sv
// Checker of the command link strobe and byte timing
`timescale 1ns/10ps
module dwc_chk (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rstn_i,
	// Link signals
	input wire logic       data_command_select,
	input wire logic       wr_n,
	input wire logic [7:0] data
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_low_len; $fell(wr_n) |-> !wr_n [*4]; endproperty
	a_low_len: assert property (p_low_len) else $error("strobe low too short");
	property p_rise_at; $fell(wr_n) |-> ##4 $rose(wr_n); endproperty
	a_rise_at: assert property (p_rise_at) else $error("strobe low too long");
	property p_high_len; $rose(wr_n) |-> wr_n [*4]; endproperty
	a_high_len: assert property (p_high_len) else $error("strobe high too short");
	property p_gap; $fell(wr_n) |-> $past(wr_n, 4); endproperty
	a_gap: assert property (p_gap) else $error("strobe fell too soon");
	property p_data_chg; $changed(data) |-> $fell(wr_n); endproperty
	a_data_chg: assert property (p_data_chg) else $error("byte moved off strobe");
	property p_dcs_chg; $changed(data_command_select) |-> $fell(wr_n); endproperty
	a_dcs_chg: assert property (p_dcs_chg) else $error("select moved off strobe");
	property p_low_hold; !wr_n && !$past(wr_n) |-> $stable({data_command_select, data});
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("byte unstable");
	property p_rise_hold; $rose(wr_n) |=> $stable(data) && $stable(data_command_select);
	endproperty
	a_rise_hold: assert property (p_rise_hold) else $error("byte not held");
endmodule : dwc_chk

// File: display_on_and_window_commands_tb.sv
// Testbench of host and device ends joined over the command link
`timescale 1ns/10ps
module display_on_and_window_commands_tb;
	import dwc_pkg::*;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [31:0] par;
		logic [63:0] win;
		logic        en;
	} dwc_row_t;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hready;
	logic        hresp;
	logic [1:0]  gm = 2'h0;
	logic        swap = 1'b0;
	logic        en;
	logic        ftp;
	logic        mws;
	logic        aok;
	logic        pv;
	logic [7:0]  pd;
	logic [7:0]  sent = 8'h0;
	logic [15:0] cs, ce, rs, re, cm, rm, acs, ace, ars, are;
	logic [15:0] lim [4] = '{16'h00cf, 16'h00db, 16'h00ef, 16'h00ef};
	dwc_row_t    rows [6];
	int          miscompares = 0;
	int          checks = 0;
	int          cyc = 0;
	int          mws_n = 0;
	int          pv_n = 0;
	int          m0;
	int          p0;

	dwc_link_if link_if ();
	dwc_host dwc_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
		.link(link_if.host));
	dwc_device dwc_device_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link_if.device),
		.gate_line_mode_i(gm), .row_column_swap_i(swap), .display_enable_o(en),
		.frame_to_panel_o(ftp), .column_start_o(cs), .column_end_o(ce), .row_start_o(rs),
		.row_end_o(re), .column_max_o(cm), .row_max_o(rm), .memory_write_start_o(mws),
		.act_column_start_o(acs), .act_column_end_o(ace), .act_row_start_o(ars),
		.act_row_end_o(are), .act_window_ok_o(aok), .pixel_data_o(pd), .pixel_valid_o(pv));
	dwc_chk dwc_chk_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.data_command_select(link_if.data_command_select), .wr_n(link_if.wr_n),
		.data(link_if.data));

	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp32

	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		cmp32({16'h0, g}, {16'h0, e});
	endtask : cmp16

	task automatic cmp1(input logic g, input logic e);
		cmp32({31'h0, g}, {31'h0, e});
	endtask : cmp1

	// One single word transfer, entered just after a rising edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic send(input logic p, input logic [7:0] b);
		ahb(1'b1, DWC_SEND_OFF, {23'h0, p, b});
		sent++;
	endtask : send

	task automatic cmd4(input logic [7:0] c, input logic [31:0] p, input int n);
		send(1'b0, c);
		for (int k = 0; k < n; k++)
			send(1'b1, p[31 - 8 * k -: 8]);
		repeat (16) @(posedge clk_i);
	endtask : cmd4

	task automatic defaults(input logic [15:0] e);
		cmp1(en, 1'b0);
		cmp1(ftp, 1'b0);
		cmp16(cs, DWC_START_DEFAULT);
		cmp16(ce, DWC_MAX_176);
		cmp16(rs, DWC_START_DEFAULT);
		cmp16(re, e);
	endtask : defaults

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	// Hang guard and pulse counters
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		mws_n <= mws_n + int'(mws === 1'b1);
		pv_n <= pv_n + int'(pv === 1'b1);
		if (cyc == 5000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	initial
	begin
		rows[0] = '{DWC_CMD_COLUMN_WINDOW, 32'h0005_0064, 64'h0005_0064_0000_00cf, 1'b0};
		rows[1] = '{DWC_CMD_ROW_WINDOW, 32'h000a_00c8, 64'h0005_0064_000a_00c8, 1'b0};
		rows[2] = '{DWC_CMD_DISPLAY_ENABLE, 32'h0, 64'h0005_0064_000a_00c8, 1'b1};
		rows[3] = '{DWC_CMD_DISPLAY_ENABLE, 32'h0, 64'h0005_0064_000a_00c8, 1'b1};
		rows[4] = '{DWC_CMD_COLUMN_WINDOW, 32'h0102_0304, 64'h0102_0304_000a_00c8, 1'b1};
		rows[5] = '{DWC_CMD_ROW_WINDOW, 32'h0000_00ef, 64'h0102_0304_0000_00ef, 1'b1};
		repeat (6) @(posedge clk_i);
		cmp16(re, DWC_MAX_208);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		foreach (rows[i])
		begin
			cmd4(rows[i].cmd, rows[i].par, rows[i].cmd == DWC_CMD_DISPLAY_ENABLE ? 0 : 4);
			cmp16(cs, rows[i].win[63:48]);
			cmp16(ce, rows[i].win[47:32]);
			cmp16(rs, rows[i].win[31:16]);
			cmp16(re, rows[i].win[15:0]);
			cmp1(en, rows[i].en);
			cmp1(ftp, rows[i].en);
			$display("row %0d done", i);
		end
		m0 = mws_n;
		p0 = pv_n;
		cmd4(DWC_CMD_MEMORY_WRITE, 32'h5a00_0000, 1);
		cmp32(32'(mws_n - m0), 32'h1);
		cmp16(ace, DWC_MAX_176);
		cmp16(are, DWC_MAX_208);
		cmp16(ars, DWC_START_DEFAULT);
		cmp1(aok, 1'b0);
		cmp1(hresp, 1'b0);
		cmp32(32'(pv_n - p0), 32'h0);
		$display("clipped window done");
		cmd4(DWC_CMD_COLUMN_WINDOW, 32'h0010_0005, 4);
		send(1'b1, 8'h77);
		p0 = pv_n;
		cmd4(DWC_CMD_MEMORY_WRITE, 32'h5a00_0000, 1);
		cmp16(cs, 16'h0010);
		cmp16(ce, 16'h0005);
		cmp16(acs, 16'h0010);
		cmp1(aok, 1'b1);
		cmp32(32'(pv_n - p0), 32'h1);
		cmp16({8'h0, pd}, 16'h005a);
		ahb(1'b0, DWC_STATUS_OFF, DWC_ZERO_WORD);
		cmp16({rd[15:8], 6'h0, rd[1:0]}, {sent, 8'h02});
		ahb(1'b1, DWC_STATUS_OFF, 32'h2);
		ahb(1'b0, DWC_STATUS_OFF, DWC_ZERO_WORD);
		cmp1(rd[1], 1'b0);
		ahb(1'b0, 8'h08, DWC_ZERO_WORD);
		cmp32(rd, DWC_ZERO_WORD);
		cmd4(DWC_CMD_ROW_WINDOW, 32'h0020_0010, 4);
		ahb(1'b0, DWC_STATUS_OFF, DWC_ZERO_WORD);
		cmp1(rd[1], 1'b1);
		$display("order and pixel done");
		for (int j = 0; j < 8; j++)
		begin
			gm <= 2'(j / 2);
			swap <= 1'(j % 2);
			repeat (8) @(posedge clk_i);
			cmp16(cm, swap ? lim[gm] : DWC_MAX_176);
			cmp16(rm, swap ? DWC_MAX_176 : lim[gm]);
		end
		$display("limits done");
		swap <= 1'b0;
		cmd4(DWC_CMD_SOFT_RESET, 32'h0, 0);
		defaults(DWC_MAX_240);
		$display("soft reset done");
		cmd4(DWC_CMD_DISPLAY_ENABLE, 32'h0, 0);
		cmp1(en, 1'b1);
		gm <= 2'h1;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		cmp1(en, 1'b0);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		defaults(DWC_MAX_220);
		$display("hardware reset done");
		end_of_test();
	end
endmodule : display_on_and_window_commands_tb
